/* ring_osc_counter.v */
// one free-running ring oscillator counter with enable crossing
`timescale 1ns/1ps
module ring_osc_counter (
  input wire osc_clk,
  input wire run,
  output wire [15:0] count
);
  reg run_s1_q;
  reg run_s2_q;
  reg run_s3_q;
  // power-up value only; a reset path would break count retention
  reg [15:0] count_q = 16'h0000;
  // ****************************************
  // enable synchroniser and counter
  // ****************************************
  // no reset: the count must survive a system reset
  always @(posedge osc_clk) begin
    run_s1_q <= run;
    run_s2_q <= run_s1_q;
    run_s3_q <= run_s2_q;
    if (run_s2_q && run_s3_q) begin
      count_q <= count_q + 16'h0001; // asynchronous to tile clock
    end
  end
  assign count = count_q;
endmodule // ring_osc_counter

/* testbench.sv */
// self-checking bench for the tile status register bank
`timescale 1ns/1ps
module testbench;
  reg clk = 0, resetn = 0, pll_clk = 0, ps_wr = 0, ps_rd = 0, otp_load = 0, debug_entry = 0, paused = 0;
  reg [3:0] osc_clk = 4'h0;
  reg [7:0] ps_addr = 8'h00;
  reg [14:0] boot = 15'h0000;
  reg [31:0] ps_wdata = 0, otp_word = 0, tssw = 32'hFFFFFFFF, rsz = 32'hDEADBEEF, msk = 32'hFFFFFFFF, rv, c1;
  wire [31:0] ps_rdata;
  wire [7:0] delay;
  wire [3:0] sect;
  wire [1:0] osc_run;
  wire ps_rvalid, tx_clk, div_act, gdd, tcd, tdd, lock_all, redund, boot_otp, port_en;
  integer err_total = 0, tests_run = 0, n;
  // ****
  // clocks and device
  // ****
  always #25 clk = ~clk;
  always #4 pll_clk = ~pll_clk;
  always #3 osc_clk = ~osc_clk;
  tile_status_register_bank tile_status_register_bank_inst (.clk(clk), .resetn(resetn), .pll_clk(pll_clk),
    .osc_clk(osc_clk), .ps_wr(ps_wr), .ps_rd(ps_rd), .ps_addr(ps_addr), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata),
    .ps_rvalid(ps_rvalid), .processor_number(boot[14:7]), .boot_pll_mode_pins(boot[6:5]),
    .boot_mode_override(boot[4]), .second_core_off(boot[3]), .otp_poll_skip(boot[2]), .boot_from_ram(boot[1]),
    .boot_from_tap(boot[0]), .ram_size(rsz), .otp_load(otp_load), .otp_security_word(otp_word),
    .debug_entry(debug_entry), .thread_saved_status_word(tssw), .all_threads_paused(paused),
    .tx_data_delay(delay), .rgmii_port_enable(port_en), .rgmii_tx_clk(tx_clk), .pll_divider_active(div_act),
    .global_debug_disable(gdd), .tap_config_disable(tcd), .tap_debug_disable(tdd), .otp_lock_all(lock_all),
    .otp_sector_lock(sect), .otp_redundancy_en(redund), .boot_from_otp(boot_otp), .ring_osc_run(osc_run));
  // ****
  // access tasks
  // ****
  task cmp(input [31:0] e, input [31:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk) #1;
      ps_wr = 1;
      ps_addr = a;
      ps_wdata = d;
      @(posedge clk) #1;
      ps_wr = 0;
    end
  endtask
  // masked compare, since oscillator counts are not predictable
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge clk) #1;
      ps_rd = 1;
      ps_addr = a;
      @(posedge clk) #1;
      ps_rd = 0;
      rv = ps_rdata;
      cmp(1, {31'h0, ps_rvalid});
      cmp(e, rv & msk);
    end
  endtask
  // k high pulses the otp reload, low the debugger entry
  task strobe(input k);
    begin
      @(posedge clk) #1;
      otp_load = k;
      debug_entry = !k;
      @(posedge clk) #1;
      otp_load = 0;
      debug_entry = 0;
    end
  endtask
  task complete_run;
    begin
      if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // ****
  // tests
  // ****
  initial begin
    repeat (16) @(posedge clk);
    #1 resetn = 1;
    rd(8'h02, 0);
    rd(8'h06, 0);
    wr(8'h02, 32'hFFFFFFFF);
    rd(8'h02, 32'h03FFFF30);
    cmp({23'h0, port_en, delay}, 32'h1FF);
    cmp(0, {31'h0, div_act});
    paused = 1;
    repeat (2) @(posedge clk);
    #1 cmp(1, {31'h0, div_act});
    paused = 0;
    wr(8'h02, 32'h00000610);
    @(posedge tx_clk);
    for (n = 0; tx_clk && n < 99; n = n + 1) begin @(posedge pll_clk); #1; end
    cmp(2, n);
    for (n = 0; !tx_clk && n < 99; n = n + 1) begin @(posedge pll_clk); #1; end
    cmp(2, n);
    cmp(1, {31'h0, div_act});
    for (n = 0; n < 2; n = n + 1) begin
      boot = n ? 15'h7FFF : 15'h2A35;
      // straps pass a three-stage synchroniser before they show
      repeat (2) @(posedge clk);
      wr(8'h03, 32'hFFFFFFFF);
      rd(8'h03, {8'h00, boot[14:7], 7'h00, boot[4], 2'h0, boot[3:0], boot[6:5]});
    end
    rd(8'h0C, 32'hDEADBEEC);
    rd(8'h04, 0);
    otp_word = 32'h00005FB1;
    strobe(1);
    rd(8'h05, 32'h00005FB1);
    cmp(32'h3FF, {22'h0, gdd, tcd, tdd, lock_all, sect, redund, boot_otp});
    wr(8'h05, 32'h80000001);
    wr(8'h05, 32'h00005FB1);
    rd(8'h05, 32'h80000001);
    otp_word = 32'h00000010;
    strobe(1);
    wr(8'h05, 32'hFFFFFFFF);
    rd(8'h05, 32'h80005FB1);
    strobe(0);
    rd(8'h10, 32'h000007DF);
    wr(8'h10, 0);
    rd(8'h10, 32'h00000100);
    wr(8'h06, 32'hFFFFFFFF);
    rd(8'h06, 3);
    cmp(3, {30'h0, osc_run});
    wr(8'h06, 0);
    repeat (10) @(posedge clk);
    msk = 32'hFFFF0000;
    for (n = 7; n < 11; n = n + 1) rd(n[7:0], 0);
    c1 = rv;
    cmp(1, {31'h0, |c1[15:0]});
    // a system reset must leave the stopped count alone
    resetn = 0;
    repeat (3) @(posedge clk);
    #1 resetn = 1;
    rd(8'h0A, 0);
    cmp(c1, rv);
    complete_run;
  end
  // watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #100000;
    err_total = err_total + 1;
    complete_run;
  end
endmodule // testbench

/* tile_status_checker.sv */
// assertion checker for the tile status register bank
`timescale 1ns/1ps
module tile_status_checker (
  input wire clk,
  input wire resetn,
  input wire ps_wr,
  input wire ps_rd,
  input wire [7:0] ps_addr,
  input wire [31:0] ps_wdata,
  input wire [31:0] ps_rdata,
  input wire ps_rvalid,
  input wire otp_load,
  input wire [31:0] otp_security_word,
  input wire all_threads_paused,
  input wire [7:0] tx_data_delay,
  input wire rgmii_port_enable,
  input wire pll_divider_active,
  input wire global_debug_disable,
  input wire tap_debug_disable,
  input wire [1:0] ring_osc_run
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire w02 = ps_wr && ps_addr == 8'h02;
  wire w05 = ps_wr && ps_addr == 8'h05;
  wire w06 = ps_wr && ps_addr == 8'h06;
  reg lock_q, en_q, dyn_q;
  // shadow of lock and divider bits, so no internal probe is needed
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_q <= 1'b0;
      en_q <= 1'b0;
      dyn_q <= 1'b0;
    end else begin
      if (otp_load) begin
        lock_q <= otp_security_word[31];
      end else if (w05 && !lock_q) begin
        lock_q <= ps_wdata[31];
      end
      if (w02) begin
        en_q <= ps_wdata[4];
        dyn_q <= ps_wdata[5];
      end
    end
  end
  // derived outputs show a register change two edges on
  sequence lag_s; ##2 1'b1; endsequence
  rd_answer_a:
    assert property (ps_rd |=> ps_rvalid) else $error("read not answered");
  rd_quiet_a:
    assert property (!ps_rd |=> !ps_rvalid && $stable(ps_rdata)) else $error("read data moved");
  tx_delay_a:
    assert property (w02 |-> lag_s ##0 tx_data_delay == $past(ps_wdata[25:18], 2)) else $error("delay");
  port_enable_a:
    assert property (w02 |-> lag_s ##0 rgmii_port_enable == $past(ps_wdata[8], 2)) else $error("port");
  lock_hold_a:
    assert property (w05 && lock_q && !otp_load |-> lag_s ##0 $stable(tap_debug_disable)) else $error("lock");
  otp_copy_a:
    assert property (otp_load |-> lag_s ##0 {global_debug_disable, tap_debug_disable} ==
      $past({otp_security_word[14], otp_security_word[0]}, 2)) else $error("otp copy");
  divider_mode_a:
    assert property (pll_divider_active == $past(en_q && (!dyn_q || all_threads_paused))) else $error("divider");
  osc_run_a:
    assert property (w06 |-> lag_s ##0 ring_osc_run == $past(ps_wdata[1:0], 2)) else $error("osc run");
endmodule // tile_status_checker
bind tile_status_register_bank tile_status_checker tile_status_checker_inst (.clk, .resetn, .ps_wr, .ps_rd,
  .ps_addr, .ps_wdata, .ps_rdata, .ps_rvalid, .otp_load, .otp_security_word, .all_threads_paused, .tx_data_delay,
  .rgmii_port_enable, .pll_divider_active, .global_debug_disable, .tap_debug_disable, .ring_osc_run);

/* tile_status_map.vh */
// register numbers, field positions and reset values of the tile status register bank
// Operation
// - eight-bit transmit data delay, resets zero
// - pll counter sets clock high at value, low at half value
// - port enable bit connects rgmii ports
// - dynamic divider acts only when threads paused
// - divider enable divides pll for low power
// - boot status shows processor number, pll pins
// - boot status flags ram, tap, override, power
// - security register loaded from otp word
// - top security bit refuses further writes
// - three debug and tap disable bits
// - otp lock, sector locks, redundancy, boot force
// - four oscillator counters, two enable bits
// - four read-only sixteen-bit count registers
// - oscillator counts survive system reset
// - oscillators run asynchronous to tile clock
// - ram size in upper thirty bits
// - debugger entry captures saved status word
// - bit7 fast mode, bit6 paused
// - bit4 kernel, bit3 interrupt, bit2 event sequence
// - bit1 interrupt enable, bit0 event enable
// - bit10 address space, bit9 entry mode, bit8 ro
// - one-word status read and write instructions
`ifndef TILE_STATUS_MAP_VH
`define TILE_STATUS_MAP_VH
// ****************************************
// register numbers
// ****************************************
`define REG_TILE_FEATURE_CONTROL 8'h02
`define REG_TILE_BOOT_STATUS 8'h03
`define REG_SECURITY_SETTINGS 8'h05
`define REG_RING_OSC_CONTROL 8'h06
`define REG_RING_OSC_COUNT_TILE_CELL 8'h07
`define REG_RING_OSC_COUNT_TILE_WIRE 8'h08
`define REG_RING_OSC_COUNT_PERIPH_CELL 8'h09
`define REG_RING_OSC_COUNT_PERIPH_WIRE 8'h0A
`define REG_MEMORY_SIZE_BYTES 8'h0C
`define REG_DEBUG_SAVED_STATUS 8'h10
// ****************************************
// writable masks and fields
// ****************************************
`define TFC_WMASK 32'h03FFFF30
`define TFC_DELAY_HI 25
`define TFC_DELAY_LO 18
`define TFC_DIV_HI 17
`define TFC_DIV_LO 9
`define TFC_PORT_EN 8
`define TFC_DYN 5
`define TFC_DIV_EN 4
`define SEC_WMASK 32'h80005FB1
`define SEC_WLOCK 31
`define SEC_DBG_DIS 14
`define SEC_TAP_CFG_DIS 4
`define SEC_TAP_DIS 0
`define SEC_OTP_LOCK_ALL 12
`define SEC_OTP_SECT_HI 11
`define SEC_OTP_SECT_LO 8
`define SEC_OTP_REDUND 7
`define SEC_BOOT_OTP 5
`define ROC_WMASK 32'h00000003
`define ROC_CORE_EN 1
`define ROC_PERIPH_EN 0
`define SSW_WMASK 32'h000006DF
`define SSW_RMASK 32'h000007DF
`define SSW_ISSUE 8
`define RAM_SIZE_MASK 32'hFFFFFFFC
`define BOOT_MASK 32'h00FF013F
`define ZERO32 32'h00000000
`define ZERO9 9'h000
`define CNT_WIDTH 16
`endif

/* tile_status_register_bank.v */
// tile processor status register bank
`timescale 1ns/1ps
`include "tile_status_map.vh"
module tile_status_register_bank (
  input wire clk,
  input wire resetn,
  input wire pll_clk,
  input wire [3:0] osc_clk,
  input wire ps_wr,
  input wire ps_rd,
  input wire [7:0] ps_addr,
  input wire [31:0] ps_wdata,
  output reg [31:0] ps_rdata,
  output reg ps_rvalid,
  input wire [7:0] processor_number,
  input wire [1:0] boot_pll_mode_pins,
  input wire boot_mode_override,
  input wire second_core_off,
  input wire otp_poll_skip,
  input wire boot_from_ram,
  input wire boot_from_tap,
  input wire [31:0] ram_size,
  input wire otp_load,
  input wire [31:0] otp_security_word,
  input wire debug_entry,
  input wire [31:0] thread_saved_status_word,
  input wire all_threads_paused,
  output reg [7:0] tx_data_delay,
  output reg rgmii_port_enable,
  output reg rgmii_tx_clk,
  output reg pll_divider_active,
  output reg global_debug_disable,
  output reg tap_config_disable,
  output reg tap_debug_disable,
  output reg otp_lock_all,
  output reg [3:0] otp_sector_lock,
  output reg otp_redundancy_en,
  output reg boot_from_otp,
  output reg [1:0] ring_osc_run
);
  reg [31:0] tfc_q;
  reg [31:0] sec_q;
  reg [31:0] roc_q;
  reg [31:0] ssw_q;
  reg [31:0] boot_q;
  reg [31:0] ram_q;
  reg [31:0] rdata_d;
  wire [15:0] cnt [0:3];
  wire sec_locked;
  wire [14:0] strap_pins;
  reg [14:0] strap_s1_q;
  reg [14:0] strap_s2_q;
  reg [14:0] strap_s3_q;
  // ****************************************
  // strap pin synchroniser
  // ****************************************
  assign strap_pins = {processor_number, boot_pll_mode_pins, boot_mode_override, second_core_off, otp_poll_skip,
                       boot_from_ram, boot_from_tap};
  // straps come from pins; three stages, taken once the last two agree
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_s1_q <= 15'h0000;
      strap_s2_q <= 15'h0000;
      strap_s3_q <= 15'h0000;
    end else begin
      strap_s1_q <= strap_pins;
      strap_s2_q <= strap_s1_q;
      strap_s3_q <= strap_s2_q;
    end
  end
  // ****************************************
  // register writes
  // ****************************************
  assign sec_locked = sec_q[`SEC_WLOCK];
  // one word per instruction; masks keep reserved bits zero, ro bits keep their value
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tfc_q <= `ZERO32;
      sec_q <= `ZERO32;
      roc_q <= `ZERO32;
      ssw_q <= `ZERO32;
      boot_q <= `ZERO32;
      ram_q <= `ZERO32;
    end else begin
      // size is sampled every cycle, straps whenever the last two stages agree; never at reset itself
      if (strap_s2_q == strap_s3_q) begin
        boot_q <= {8'h00, strap_s3_q[14:7], 7'h00, strap_s3_q[4], 2'b00,
                   strap_s3_q[3:0], strap_s3_q[6:5]};
      end
      ram_q <= ram_size & `RAM_SIZE_MASK;
      if (ps_wr && ps_addr == `REG_TILE_FEATURE_CONTROL) begin
        tfc_q <= ps_wdata & `TFC_WMASK;
      end
      // otp reload wins; it and reset are the only ways to drop the lock
      if (otp_load) begin
        sec_q <= otp_security_word & `SEC_WMASK;
      end else if (ps_wr && ps_addr == `REG_SECURITY_SETTINGS && !sec_locked) begin
        sec_q <= ps_wdata & `SEC_WMASK;
      end
      if (ps_wr && ps_addr == `REG_RING_OSC_CONTROL) begin
        roc_q <= ps_wdata & `ROC_WMASK;
      end
      // capture on debugger entry beats a simultaneous debugger write
      if (debug_entry) begin
        ssw_q <= thread_saved_status_word & `SSW_RMASK;
      end else if (ps_wr && ps_addr == `REG_DEBUG_SAVED_STATUS) begin
        ssw_q <= (ps_wdata & `SSW_WMASK) | (ssw_q & ~`SSW_WMASK);
      end
    end
  end
  // ****************************************
  // read mux
  // ****************************************
  always @* begin
    case (ps_addr)
      `REG_TILE_FEATURE_CONTROL: rdata_d = tfc_q;
      `REG_TILE_BOOT_STATUS: rdata_d = boot_q & `BOOT_MASK;
      `REG_SECURITY_SETTINGS: rdata_d = sec_q;
      `REG_RING_OSC_CONTROL: rdata_d = roc_q;
      `REG_RING_OSC_COUNT_TILE_CELL: rdata_d = {16'h0000, cnt[0]};
      `REG_RING_OSC_COUNT_TILE_WIRE: rdata_d = {16'h0000, cnt[1]};
      `REG_RING_OSC_COUNT_PERIPH_CELL: rdata_d = {16'h0000, cnt[2]};
      `REG_RING_OSC_COUNT_PERIPH_WIRE: rdata_d = {16'h0000, cnt[3]};
      `REG_MEMORY_SIZE_BYTES: rdata_d = ram_q;
      `REG_DEBUG_SAVED_STATUS: rdata_d = ssw_q;
      default: rdata_d = `ZERO32;
    endcase
  end
  // counts are sampled raw; software waits ten cycles after stop
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ps_rdata <= `ZERO32;
      ps_rvalid <= 1'b0;
    end else begin
      ps_rvalid <= ps_rd;
      if (ps_rd) begin
        ps_rdata <= rdata_d;
      end
    end
  end
  // ****************************************
  // control outputs
  // ****************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_data_delay <= 8'h00;
      rgmii_port_enable <= 1'b0;
      pll_divider_active <= 1'b0;
      global_debug_disable <= 1'b0;
      tap_config_disable <= 1'b0;
      tap_debug_disable <= 1'b0;
      otp_lock_all <= 1'b0;
      otp_sector_lock <= 4'h0;
      otp_redundancy_en <= 1'b0;
      boot_from_otp <= 1'b0;
      ring_osc_run <= 2'b00;
    end else begin
      tx_data_delay <= tfc_q[`TFC_DELAY_HI:`TFC_DELAY_LO];
      rgmii_port_enable <= tfc_q[`TFC_PORT_EN];
      // dynamic mode gates the divider on all threads paused
      pll_divider_active <= tfc_q[`TFC_DIV_EN] & (~tfc_q[`TFC_DYN] | all_threads_paused);
      global_debug_disable <= sec_q[`SEC_DBG_DIS];
      tap_config_disable <= sec_q[`SEC_TAP_CFG_DIS];
      tap_debug_disable <= sec_q[`SEC_TAP_DIS];
      otp_lock_all <= sec_q[`SEC_OTP_LOCK_ALL];
      otp_sector_lock <= sec_q[`SEC_OTP_SECT_HI:`SEC_OTP_SECT_LO];
      otp_redundancy_en <= sec_q[`SEC_OTP_REDUND];
      boot_from_otp <= sec_q[`SEC_BOOT_OTP];
      ring_osc_run <= roc_q[`ROC_CORE_EN:`ROC_PERIPH_EN];
    end
  end
  // ****************************************
  // rgmii transmit clock divider on pll clock
  // ****************************************
  reg [8:0] div_s1_q;
  reg [8:0] div_s2_q;
  reg [8:0] div_s3_q;
  reg [8:0] div_q;
  reg [8:0] div_cnt_q;
  reg rst_s1_q;
  reg rst_s2_q;
  // field is ratio minus one, so counter wraps at the value
  // divider field is quasi-static; three stages and an agreement check guard metastability and torn samples
  always @(posedge pll_clk or negedge resetn) begin
    if (!resetn) begin
      div_s1_q <= `ZERO9;
      div_s2_q <= `ZERO9;
      div_s3_q <= `ZERO9;
      div_q <= `ZERO9;
      div_cnt_q <= `ZERO9;
      rgmii_tx_clk <= 1'b0;
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
      div_s1_q <= tfc_q[`TFC_DIV_HI:`TFC_DIV_LO];
      div_s2_q <= div_s1_q;
      div_s3_q <= div_s2_q;
      // a torn multi-bit sample never agrees twice, so it is not taken
      if (div_s2_q == div_s3_q) begin
        div_q <= div_s3_q;
      end
      if (rst_s2_q) begin
        if (div_cnt_q >= div_q) begin
          div_cnt_q <= `ZERO9;
        end else begin
          div_cnt_q <= div_cnt_q + 9'h001;
        end
        if (div_cnt_q == div_q) begin
          rgmii_tx_clk <= 1'b1;
        end else if (div_cnt_q == (div_q >> 1)) begin
          rgmii_tx_clk <= 1'b0;
        end
      end
    end
  end
  // ****************************************
  // ring oscillator counters
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_osc
      // counters 0,1 are core side, 2,3 peripheral side
      ring_osc_counter u_cnt (
        .osc_clk(osc_clk[gi]),
        .run((gi < 2) ? roc_q[`ROC_CORE_EN] : roc_q[`ROC_PERIPH_EN]),
        .count(cnt[gi])
      );
    end
  endgenerate
endmodule // tile_status_register_bank
